// ---- hw/load_pkg.sv ----
// shared types and constants for the single-register load decode and execute block
//
// Notes on behaviour
// - Failed condition check leaves no architectural effect
// - Immediate offset added or subtracted per add
// - Index picks address; writeback stores offset address
// - Program counter load needs word-aligned address
// - Loaded branch target bit zero clear: usage fault
// - Usage, memory management, bus faults reported
// - Short literal immediate scaled by four, added
// - Wide literal immediate unscaled, up bit signs
// - Literal base is program counter aligned down
// - Literal offsets: 0..1020 short, +-4095 wide
// - Wide PC load mid conditional block unpredictable
// - Wide word base field all ones: literal
// - Short register form: add, pre-index, no writeback
// - Offset register shifted left by zero to three
// - Wide offset register SP or PC unpredictable
// - Byte loads zero-extend to full word
// - Short byte immediate unscaled, 0..31, added
// - Wide byte offsets 0..4095 and 0..255
// - Wide byte destination all ones: preload hint, except indexed forms with P U W other than 100
// - Indexed byte uses P U W; odd combos undefined
// - Indexed byte destination and writeback restrictions
package load_pkg;
  localparam int unsigned XLEN = 32;
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [31:0] ALIGN_MASK = 32'h00000003;
  localparam int unsigned WORD_SCALE = 2;
  localparam int unsigned HW1_U_BIT = 3;
  localparam logic [4:0] OP16_WORD_IMM = 5'h0D;
  localparam logic [4:0] OP16_WORD_SP = 5'h13;
  localparam logic [4:0] OP16_WORD_LIT = 5'h09;
  localparam logic [4:0] OP16_BYTE_IMM = 5'h0F;
  localparam logic [6:0] OP16_WORD_REG = 7'h2C;
  localparam logic [11:0] OP32_WORD_IMM_TWELVE_FIELD = 12'hF8D;
  localparam logic [11:0] OP32_WORD_IMM_EIGHT_FIELD = 12'hF85;
  localparam logic [11:0] OP32_BYTE_IMM_TWELVE_FIELD = 12'hF89;
  localparam logic [11:0] OP32_BYTE_IMM_EIGHT_FIELD = 12'hF81;
  localparam logic [2:0] PUW_HINT = 3'h4;
  localparam logic [2:0] PUW_UNPRIV = 3'h6;

  typedef struct packed {logic [15:0] hi; logic [15:0] lo;} word_s;
  typedef struct packed {
    logic [4:0] op; logic [4:0] imm; logic [2:0] base_reg; logic [2:0] dest_reg;
  } t16_imm_five_field_s;
  typedef struct packed {logic [4:0] op; logic [2:0] dest_reg; logic [7:0] imm;} t16_imm_eight_field_s;
  typedef struct packed {
    logic [6:0] op; logic [2:0] offs_reg; logic [2:0] base_reg; logic [2:0] dest_reg;
  } t16_reg_s;
  typedef struct packed {logic [11:0] op; logic [3:0] base_reg;} hw1_s;
  typedef struct packed {logic [3:0] dest_reg; logic [11:0] imm;} hw2_imm_twelve_field_s;
  typedef struct packed {
    logic [3:0] dest_reg; logic mark; logic p; logic u; logic w; logic [7:0] imm;
  } hw2_imm_eight_field_s;
  typedef struct packed {
    logic [3:0] dest_reg; logic [5:0] zero; logic [1:0] sh; logic [3:0] offs_reg;
  } hw2_reg_s;

  // one instruction offered by the core, with its context
  typedef struct packed {
    logic valid;
    logic wide;
    word_s bits;
    logic cond_pass;
    logic in_block;
    logic last_in_block;
    logic [31:0] pc;
  } instr_s;

  // decoded operation
  typedef struct packed {
    logic byte_sz;
    logic literal;
    logic reg_form;
    logic index;
    logic add;
    logic wback;
    logic [1:0] shift;
    logic [3:0] dest_reg;
    logic [3:0] base_reg;
    logic [3:0] offs_reg;
    logic [31:0] imm;
  } op_s;

  typedef struct packed {logic valid; logic [31:0] addr; logic byte_sz;} mem_req_s;
  typedef struct packed {logic ack; logic [31:0] data; logic bus_err; logic mpu_err;} mem_rsp_s;
  typedef struct packed {logic en; logic [3:0] idx; logic [31:0] data;} reg_wr_s;
  typedef struct packed {
    logic usage; logic mem_mgmt; logic bus; logic undef; logic unpred;
  } except_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WAIT = 3'b100
  } state_e;
endpackage

// ---- hw/load_addr_gen.sv ----
// address generation: base or aligned pc, scaled register or immediate offset
`timescale 1ns/1ns
module load_addr_gen (
  // operands
  input wire logic [31:0] base_in,
  input wire logic [31:0] offs_in,
  input wire logic [31:0] pc_in,
  input wire load_pkg::op_s op_in,
  // results
  output logic [31:0] addr_out,
  output logic [31:0] offs_addr_out
);
  logic [31:0] base;
  logic [31:0] offset;

  assign base = op_in.literal ? (pc_in & ~load_pkg::ALIGN_MASK) : base_in;
  assign offset = op_in.reg_form ? (offs_in << op_in.shift) : op_in.imm;
  assign offs_addr_out = op_in.add ? (base + offset) : (base - offset);
  assign addr_out = op_in.index ? offs_addr_out : base;
endmodule

// ---- hw/load_exec.sv ----
// decode and execute of single-register word and byte loads
`timescale 1ns/1ns
module load_exec (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // instruction from the core
  input wire load_pkg::instr_s instr_in,
  output logic ready_out,
  // register file read, value returned in the same cycle as the index
  output logic [3:0] base_idx_out,
  output logic [3:0] offs_idx_out,
  input wire logic [31:0] base_val_in,
  input wire logic [31:0] offs_val_in,
  // memory load interface
  output load_pkg::mem_req_s mem_req_out,
  input wire load_pkg::mem_rsp_s mem_rsp_in,
  // results
  output load_pkg::reg_wr_s dest_wr_out,
  output load_pkg::reg_wr_s base_wr_out,
  output logic branch_out,
  output logic [31:0] branch_target_out,
  output load_pkg::except_s except_out,
  output logic done_out
);
  typedef struct packed {
    load_pkg::state_e state;
    load_pkg::op_s op;
    logic [31:0] pc;
    logic [31:0] offs_addr;
    logic ready;
    logic [3:0] base_idx;
    logic [3:0] offs_idx;
    load_pkg::mem_req_s req;
    load_pkg::reg_wr_s dst;
    load_pkg::reg_wr_s wb;
    logic branch;
    logic [31:0] target;
    load_pkg::except_s exc;
    logic done;
  } state_s;

  state_s s;
  state_s next_s;
  logic [31:0] ag_addr;
  logic [31:0] ag_offs_addr;
  load_pkg::op_s dec_op;
  logic dec_undef;
  logic dec_unpred;
  logic dec_hint;
  logic [31:0] ld_data;

  function automatic load_pkg::op_s decode(input load_pkg::instr_s i, output logic undef,
                                           output logic unpred, output logic hint);
    load_pkg::op_s o;
    load_pkg::t16_imm_five_field_s a5;
    load_pkg::t16_imm_eight_field_s a8;
    load_pkg::t16_reg_s ar;
    load_pkg::hw1_s h1;
    load_pkg::hw2_imm_twelve_field_s h12;
    load_pkg::hw2_imm_eight_field_s h8;
    load_pkg::hw2_reg_s hr;
    logic word;
    o = '0;
    undef = 1'b0;
    unpred = 1'b0;
    hint = 1'b0;
    word = 1'b0;
    o.index = 1'b1;
    o.add = 1'b1;
    a5 = load_pkg::t16_imm_five_field_s'(i.bits.lo);
    a8 = load_pkg::t16_imm_eight_field_s'(i.bits.lo);
    ar = load_pkg::t16_reg_s'(i.bits.lo);
    h1 = load_pkg::hw1_s'(i.bits.hi);
    h12 = load_pkg::hw2_imm_twelve_field_s'(i.bits.lo);
    h8 = load_pkg::hw2_imm_eight_field_s'(i.bits.lo);
    hr = load_pkg::hw2_reg_s'(i.bits.lo);
    if (!i.wide)
    begin
      o.dest_reg = {1'b0, a5.dest_reg};
      o.base_reg = {1'b0, a5.base_reg};
      if (a5.op == load_pkg::OP16_WORD_IMM)
        o.imm = 32'(a5.imm) << load_pkg::WORD_SCALE;
      else if (a5.op == load_pkg::OP16_BYTE_IMM)
      begin
        o.byte_sz = 1'b1;
        o.imm = 32'(a5.imm);
      end
      else if (a8.op == load_pkg::OP16_WORD_SP)
      begin
        o.dest_reg = {1'b0, a8.dest_reg};
        o.base_reg = load_pkg::REG_SP;
        o.imm = 32'(a8.imm) << load_pkg::WORD_SCALE;
      end
      else if (a8.op == load_pkg::OP16_WORD_LIT)
      begin
        o.dest_reg = {1'b0, a8.dest_reg};
        o.literal = 1'b1;
        o.imm = 32'(a8.imm) << load_pkg::WORD_SCALE;
      end
      else if (ar.op == load_pkg::OP16_WORD_REG)
      begin
        o.reg_form = 1'b1;
        o.offs_reg = {1'b0, ar.offs_reg};
      end
      else
        undef = 1'b1;
    end
    else
    begin
      o.dest_reg = h12.dest_reg;
      o.base_reg = h1.base_reg;
      o.byte_sz = (h1.op == load_pkg::OP32_BYTE_IMM_TWELVE_FIELD) || (h1.op == load_pkg::OP32_BYTE_IMM_EIGHT_FIELD);
      word = (h1.op == load_pkg::OP32_WORD_IMM_TWELVE_FIELD) || (h1.op == load_pkg::OP32_WORD_IMM_EIGHT_FIELD);
      if (!(word || o.byte_sz))
        undef = 1'b1;
      else if (o.byte_sz && h12.dest_reg == load_pkg::REG_PC &&
               !(h1.op == load_pkg::OP32_BYTE_IMM_EIGHT_FIELD && h1.base_reg != load_pkg::REG_PC &&
                 h8.mark && {h8.p, h8.u, h8.w} != load_pkg::PUW_HINT))
        hint = 1'b1;
      else if (h1.base_reg == load_pkg::REG_PC)
      begin
        o.literal = 1'b1;
        o.add = h1.op[load_pkg::HW1_U_BIT];
        o.imm = 32'(h12.imm);
        unpred = o.byte_sz && h12.dest_reg == load_pkg::REG_SP;
      end
      else if (h1.op == load_pkg::OP32_WORD_IMM_TWELVE_FIELD || h1.op == load_pkg::OP32_BYTE_IMM_TWELVE_FIELD)
      begin
        o.imm = 32'(h12.imm);
        unpred = o.byte_sz && h12.dest_reg == load_pkg::REG_SP;
      end
      else if (h8.mark)
      begin
        o.index = h8.p;
        o.add = h8.u;
        o.wback = h8.w;
        o.imm = 32'(h8.imm);
        // unprivileged form belongs to other logic; refused here
        if ({h8.p, h8.u, h8.w} == load_pkg::PUW_UNPRIV || (!h8.p && !h8.w))
          undef = 1'b1;
        else if (o.byte_sz)
          unpred = h8.dest_reg == load_pkg::REG_SP || h8.dest_reg == load_pkg::REG_PC ||
                   (h8.w && h1.base_reg == h8.dest_reg);
      end
      else if (hr.zero == '0)
      begin
        o.reg_form = 1'b1;
        o.offs_reg = hr.offs_reg;
        o.shift = hr.sh;
        unpred = hr.offs_reg == load_pkg::REG_SP || hr.offs_reg == load_pkg::REG_PC ||
                 (o.byte_sz && hr.dest_reg == load_pkg::REG_SP);
      end
      else
        undef = 1'b1;
      if (word && o.dest_reg == load_pkg::REG_PC && i.in_block && !i.last_in_block)
        unpred = 1'b1;
    end
    return o;
  endfunction

  always_comb
  begin
    dec_op = decode(instr_in, dec_undef, dec_unpred, dec_hint);
  end

  load_addr_gen i_load_addr_gen (
    .base_in(base_val_in),
    .offs_in(offs_val_in),
    .pc_in(s.pc),
    .op_in(s.op),
    .addr_out(ag_addr),
    .offs_addr_out(ag_offs_addr)
  );

  // memory returns the addressed byte in the low lane for byte loads
  assign ld_data = s.op.byte_sz ? 32'(mem_rsp_in.data[7:0]) : mem_rsp_in.data;

  always_comb
  begin
    next_s = s;
    next_s.dst.en = 1'b0;
    next_s.wb.en = 1'b0;
    next_s.branch = 1'b0;
    next_s.exc = '0;
    next_s.done = 1'b0;
    case (s.state)
      load_pkg::ST_IDLE:
      begin
        if (instr_in.valid)
        begin
          next_s.done = 1'b1;
          if (!instr_in.cond_pass)
            next_s.done = 1'b1;
          else if (dec_undef)
            next_s.exc.undef = 1'b1;
          else if (dec_unpred)
            next_s.exc.unpred = 1'b1;
          else if (!dec_hint)
          begin
            next_s.done = 1'b0;
            next_s.op = dec_op;
            next_s.pc = instr_in.pc;
            next_s.base_idx = dec_op.base_reg;
            next_s.offs_idx = dec_op.offs_reg;
            next_s.state = load_pkg::ST_READ;
          end
        end
      end
      load_pkg::ST_READ:
      begin
        if (s.op.dest_reg == load_pkg::REG_PC && (ag_addr & load_pkg::ALIGN_MASK) != '0)
        begin
          next_s.exc.unpred = 1'b1;
          next_s.done = 1'b1;
          next_s.state = load_pkg::ST_IDLE;
        end
        else
        begin
          next_s.req.valid = 1'b1;
          next_s.req.addr = ag_addr;
          next_s.req.byte_sz = s.op.byte_sz;
          next_s.offs_addr = ag_offs_addr;
          next_s.state = load_pkg::ST_WAIT;
        end
      end
      load_pkg::ST_WAIT:
      begin
        // request stands until the memory side answers
        if (mem_rsp_in.ack)
        begin
          next_s.req.valid = 1'b0;
          next_s.done = 1'b1;
          next_s.state = load_pkg::ST_IDLE;
          if (mem_rsp_in.bus_err)
            next_s.exc.bus = 1'b1;
          else if (mem_rsp_in.mpu_err)
            next_s.exc.mem_mgmt = 1'b1;
          else
          begin
            next_s.wb.en = s.op.wback;
            next_s.wb.idx = s.op.base_reg;
            next_s.wb.data = s.offs_addr;
            if (s.op.dest_reg == load_pkg::REG_PC)
            begin
              if (ld_data[0])
              begin
                next_s.branch = 1'b1;
                next_s.target = {ld_data[31:1], 1'b0};
              end
              else
                next_s.exc.usage = 1'b1;
            end
            else
            begin
              next_s.dst.en = 1'b1;
              next_s.dst.idx = s.op.dest_reg;
              next_s.dst.data = ld_data;
            end
          end
        end
      end
      default:
      begin
        next_s = '0;
        next_s.state = load_pkg::ST_IDLE;
      end
    endcase
    next_s.ready = next_s.state == load_pkg::ST_IDLE;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s <= '0;
      s.state <= load_pkg::ST_IDLE;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign ready_out = s.ready;
  assign base_idx_out = s.base_idx;
  assign offs_idx_out = s.offs_idx;
  assign mem_req_out = s.req;
  assign dest_wr_out = s.dst;
  assign base_wr_out = s.wb;
  assign branch_out = s.branch;
  assign branch_target_out = s.target;
  assign except_out = s.exc;
  assign done_out = s.done;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  cond_fail_a: assert property (
    s.ready && instr_in.valid && !instr_in.cond_pass |=>
      done_out && !mem_req_out.valid ##1 !mem_req_out.valid && !dest_wr_out.en)
    else $error("failed condition still acted");
  index_addr_a: assert property (
    mem_req_out.valid && s.op.index |-> mem_req_out.addr == s.offs_addr)
    else $error("indexed address differs from offset address");
  post_addr_a: assert property (
    mem_req_out.valid && !s.op.index |->
      s.offs_addr == (s.op.add ? mem_req_out.addr + s.op.imm : mem_req_out.addr - s.op.imm))
    else $error("post-index offset address wrong");
  literal_base_a: assert property (
    mem_req_out.valid && s.op.literal |-> mem_req_out.addr == (s.op.add ?
      (s.pc & ~load_pkg::ALIGN_MASK) + s.op.imm : (s.pc & ~load_pkg::ALIGN_MASK) - s.op.imm))
    else $error("literal address wrong");
  pc_align_a: assert property (
    s.state == load_pkg::ST_READ && s.op.dest_reg == load_pkg::REG_PC && ag_addr[1:0] != 2'h0 |=>
      except_out.unpred && !mem_req_out.valid)
    else $error("misaligned pc load issued");
  interwork_bit_a: assert property (
    s.state == load_pkg::ST_WAIT && mem_rsp_in.ack && !mem_rsp_in.bus_err &&
      !mem_rsp_in.mpu_err && s.op.dest_reg == load_pkg::REG_PC |=>
      (branch_out != except_out.usage) && !dest_wr_out.en)
    else $error("pc load result not branch xor usage fault");
  hold_req_a: assert property (
    mem_req_out.valid && !mem_rsp_in.ack |=> mem_req_out.valid && $stable(mem_req_out.addr))
    else $error("load request dropped before answer");
  bus_fault_a: assert property (
    s.state == load_pkg::ST_WAIT && mem_rsp_in.ack && mem_rsp_in.bus_err |=>
      except_out.bus && !dest_wr_out.en && !base_wr_out.en && done_out)
    else $error("bus fault not reported");
  byte_zext_a: assert property (
    dest_wr_out.en && s.op.byte_sz |-> dest_wr_out.data[31:8] == 24'h000000)
    else $error("byte load not zero-extended");

  branch_c: cover property (branch_out);
  post_wb_c: cover property (base_wr_out.en && !s.op.index);
  byte_done_c: cover property (dest_wr_out.en && s.op.byte_sz);
endmodule

// ---- verif/load_mem_model.sv ----
// memory system model answering single word or byte loads
`timescale 1ns/1ns
module load_mem_model (
  // clock
  input wire logic mclk_in,
  // request and test controls
  input wire load_pkg::mem_req_s mem_req_in,
  input wire logic [3:0] delay_in,
  input wire logic [1:0] fault_in,
  // answer
  output load_pkg::mem_rsp_s mem_rsp_out
);
  logic [3:0] cnt;
  logic [31:0] word;
  initial
  begin
    cnt = 4'h0;
    mem_rsp_out = '0;
  end
  // data is a fixed scramble of the address, inverted low half swapped with the high half
  assign word = {~mem_req_in.addr[15:0], mem_req_in.addr[31:16]} ^ 32'h0F0F1E25;
  always @(posedge mclk_in)
  begin
    mem_rsp_out.ack <= 1'b0;
    // released lines flip so stale data never looks like an answer
    mem_rsp_out.data <= ~mem_rsp_out.data;
    mem_rsp_out.bus_err <= ~mem_rsp_out.bus_err;
    mem_rsp_out.mpu_err <= ~mem_rsp_out.mpu_err;
    if (!mem_req_in.valid || mem_rsp_out.ack)
      cnt <= 4'h0;
    else if (cnt != delay_in)
      cnt <= cnt + 4'h1;
    else
    begin
      // one answer, data or fault, for every request
      mem_rsp_out.ack <= 1'b1;
      mem_rsp_out.data <= word;
      mem_rsp_out.bus_err <= fault_in[0];
      mem_rsp_out.mpu_err <= fault_in[1];
    end
  end
endmodule

// ---- verif/load_exec_bench.sv ----
// self-checking bench for the load decode and execute block
`timescale 1ns/1ns
module load_exec_bench;
  localparam load_pkg::reg_wr_s NO = '0;
  localparam load_pkg::except_s XN = '0;
  localparam load_pkg::except_s UNP = 5'h01;
  localparam load_pkg::except_s UND = 5'h02;
  localparam load_pkg::except_s BUS = 5'h04;
  localparam load_pkg::except_s MPU = 5'h08;
  localparam load_pkg::except_s USE = 5'h10;
  logic mclk_in;
  logic srst_in;
  load_pkg::instr_s instr;
  load_pkg::instr_s ci;
  logic ready;
  logic [3:0] base_idx;
  logic [3:0] offs_idx;
  load_pkg::mem_req_s mem_req;
  load_pkg::mem_rsp_s mem_rsp;
  load_pkg::reg_wr_s dest_wr;
  load_pkg::reg_wr_s base_wr;
  logic branch;
  logic [31:0] target;
  load_pkg::except_s exc;
  logic done;
  logic [3:0] delay;
  logic [1:0] fault;
  logic [31:0] regs [16];
  logic [31:0] a;
  logic [31:0] pc;
  logic [7:0] i8;
  logic [4:0] k;
  logic [2:0] breg;
  logic [2:0] dreg;
  int fails;
  int checks_done;
  int i;

  load_exec i_load_exec (.mclk_in(mclk_in), .srst_in(srst_in), .instr_in(instr),
    .ready_out(ready), .base_idx_out(base_idx), .offs_idx_out(offs_idx),
    .base_val_in(regs[base_idx]), .offs_val_in(regs[offs_idx]), .mem_req_out(mem_req),
    .mem_rsp_in(mem_rsp), .dest_wr_out(dest_wr), .base_wr_out(base_wr), .branch_out(branch),
    .branch_target_out(target), .except_out(exc), .done_out(done));
  load_mem_model i_load_mem_model (.mclk_in(mclk_in), .mem_req_in(mem_req),
    .delay_in(delay), .fault_in(fault), .mem_rsp_out(mem_rsp));

  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] mw(input logic [31:0] ad);
    return {~ad[15:0], ad[31:16]} ^ 32'h0F0F1E25;
  endfunction

  function automatic logic [31:0] mb(input logic [31:0] ad);
    return {24'h0, ad[23:16] ^ 8'h25};
  endfunction

  function automatic load_pkg::reg_wr_s w(input logic [3:0] idx, input logic [31:0] d);
    return load_pkg::reg_wr_s'({1'b1, idx, d});
  endfunction

  function automatic load_pkg::instr_s op(input logic wd, input logic [31:0] b,
    input logic [31:0] p);
    return load_pkg::instr_s'({1'b1, wd, b, 3'b100, p});
  endfunction

  task automatic chk_wr(input string what, input load_pkg::reg_wr_s got,
    input load_pkg::reg_wr_s exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input string what, input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_exc(input load_pkg::except_s got, input load_pkg::except_s exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: exceptions got %b expected %b", $time, got, exp);
    end
  endtask

  // memory address travels as data with byte size in idx
  task automatic run(input load_pkg::instr_s ins, input logic [1:0] flt,
    input load_pkg::reg_wr_s em, input load_pkg::reg_wr_s ed, input load_pkg::reg_wr_s eb,
    input load_pkg::reg_wr_s ebr, input load_pkg::except_s ex);
    load_pkg::reg_wr_s gm;
    load_pkg::reg_wr_s gd;
    load_pkg::reg_wr_s gb;
    load_pkg::reg_wr_s gbr;
    load_pkg::except_s gx;
    int n;
    gm = NO;
    gd = NO;
    gb = NO;
    gbr = NO;
    gx = XN;
    @(posedge mclk_in);
    instr <= ins;
    fault <= flt;
    delay <= 4'($urandom_range(0, 9));
    @(posedge mclk_in);
    instr.valid <= 1'b0;
    for (n = 0; n < 40; n++)
    begin
      #1;
      if (mem_req.valid === 1'b1)
        gm = w({3'h0, mem_req.byte_sz}, mem_req.addr);
      if (dest_wr.en === 1'b1)
        gd = dest_wr;
      if (base_wr.en === 1'b1)
        gb = base_wr;
      if (branch === 1'b1)
        gbr = w(4'h0, target);
      gx = gx | exc;
      if (done === 1'b1)
      begin
        chk_bit("ready with done", ready, 1'b1);
        break;
      end
      @(posedge mclk_in);
    end
    if (n == 40)
    begin
      fails++;
      $display("CHECK FAILED at %0t: instruction never completed", $time);
    end
    chk_wr("memory", gm, em);
    chk_wr("dest", gd, ed);
    chk_wr("writeback", gb, eb);
    chk_wr("branch", gbr, ebr);
    chk_exc(gx, ex);
    $display("test ended at %0t", $time);
  endtask

  task automatic ldw(input load_pkg::instr_s ins, input logic [3:0] d, input logic [31:0] ad);
    run(ins, 2'h0, w(4'h0, ad), w(d, mw(ad)), NO, NO, XN);
  endtask

  task automatic ldb(input load_pkg::instr_s ins, input logic [3:0] d, input logic [31:0] ad);
    run(ins, 2'h0, w(4'h1, ad), w(d, mb(ad)), NO, NO, XN);
  endtask

  task automatic bad(input load_pkg::instr_s ins, input load_pkg::except_s ex);
    run(ins, 2'h0, NO, NO, NO, NO, ex);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #40000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    fails = 0;
    checks_done = 0;
    srst_in = 1'b1;
    instr = '0;
    delay = 4'h0;
    fault = 2'h0;
    a = $urandom(32'h2813);
    for (i = 0; i < 16; i++)
      regs[i] = $urandom;
    regs[4] = 32'h00020000;
    regs[5] = 32'h00010000;
    regs[6] = 32'h00030002;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    for (i = 0; i < 24; i++)
    begin
      k = 5'($urandom);
      breg = 3'($urandom);
      dreg = 3'($urandom);
      i8 = 8'($urandom);
      pc = $urandom;
      if (i % 3 == 0)
        ldw(op(0, {16'h0, 5'h0D, k, breg, dreg}, 0), {1'b0, dreg},
          regs[breg] + {k, 2'b00});
      else if (i % 3 == 1)
        ldb(op(0, {16'h0, 5'h0F, k, breg, dreg}, 0), {1'b0, dreg},
          regs[breg] + k);
      else
        ldw(op(0, {16'h0, 5'h09, dreg, i8}, pc), {1'b0, dreg},
          {pc[31:2], 2'b00} + {i8, 2'b00});
    end
    ldw(op(0, {16'h0, 5'h09, 3'h5, 8'hFF}, 32'h1002), 5, 32'h1000 + 1020);
    ldw(op(1, {12'hF85, 4'hF, 4'h2, 12'hFFF}, 32'h2003), 2, 32'h2000 - 4095);
    ldw(op(0, {16'h0, 7'h2C, 3'h1, 3'h2, 3'h3}, 0), 3, regs[2] + regs[1]);
    ldw(op(0, {16'h0, 5'h13, 3'h4, 8'h10}, 0), 4, regs[13] + 32'h40);
    bad(op(0, 32'h00000000, 0), UND);
    a = regs[3] - 8;
    run(op(1, {12'hF85, 4'h3, 4'h6, 4'hD, 8'h08}, 0), 0, w(0, a), w(6, mw(a)), w(3, a), NO,
      XN);
    ldw(op(1, {12'hF85, 4'h7, 4'h8, 6'h0, 2'h3, 4'h9}, 0), 8, regs[7] + (regs[9] << 3));
    bad(op(1, {12'hF85, 4'h7, 4'h8, 6'h0, 2'h1, 4'hD}, 0), UNP);
    bad(op(1, {12'hF85, 4'h7, 4'h8, 6'h0, 2'h0, 4'hF}, 0), UNP);
    a = regs[3];
    run(op(1, {12'hF81, 4'h3, 4'h1, 4'h9, 8'hFF}, 0), 0, w(1, a), w(1, mb(a)), w(3, a - 255), NO,
      XN);
    a = regs[3] + 16;
    run(op(1, {12'hF81, 4'h3, 4'h1, 4'hF, 8'h10}, 0), 0, w(1, a), w(1, mb(a)), w(3, a), NO,
      XN);
    ldb(op(1, {12'hF89, 4'h2, 4'h4, 12'hFFF}, 0), 4, regs[2] + 4095);
    bad(op(1, {12'hF81, 4'h3, 4'h1, 4'hA, 8'h01}, 0), UND);
    bad(op(1, {12'hF81, 4'h3, 4'h1, 4'hE, 8'h01}, 0), UND);
    bad(op(1, {12'hF89, 4'h2, 4'hF, 12'h123}, 0), XN);
    bad(op(1, {12'hF89, 4'h2, 4'hD, 12'h123}, 0), UNP);
    bad(op(1, {12'hF81, 4'h3, 4'hD, 4'hC, 8'h01}, 0), UNP);
    bad(op(1, {12'hF81, 4'h3, 4'h3, 4'hB, 8'h01}, 0), UNP);
    bad(op(1, {12'hF81, 4'h3, 4'hF, 4'hF, 8'h01}, 0), UNP);
    ci = op(0, {16'h0, 5'h0D, 5'h01, 3'h2, 3'h3}, 0);
    ci.cond_pass = 1'b0;
    bad(ci, XN);
    a = regs[4];
    run(op(1, {12'hF8D, 4'h4, 4'hF, 12'h000}, 0), 0, w(0, a), NO, NO, w(0, mw(a) & ~32'h1),
      XN);
    run(op(1, {12'hF8D, 4'h5, 4'hF, 12'h000}, 0), 0, w(0, regs[5]), NO, NO, NO, USE);
    bad(op(1, {12'hF8D, 4'h6, 4'hF, 12'h000}, 0), UNP);
    ci = op(1, {12'hF8D, 4'h4, 4'hF, 12'h000}, 0);
    ci.in_block = 1'b1;
    bad(ci, UNP);
    ci.last_in_block = 1'b1;
    run(ci, 0, w(0, a), NO, NO, w(0, mw(a) & ~32'h1), XN);
    a = regs[2] + 4;
    run(op(0, {16'h0, 5'h0D, 5'h01, 3'h2, 3'h3}, 0), 1, w(0, a), NO, NO, NO, BUS);
    run(op(0, {16'h0, 5'h0D, 5'h01, 3'h2, 3'h3}, 0), 2, w(0, a), NO, NO, NO, MPU);
    run(op(0, {16'h0, 5'h0D, 5'h01, 3'h2, 3'h3}, 0), 3, w(0, a), NO, NO, NO, BUS);
    summarize();
  end
endmodule
